// *** rtl/rmd_pkg.sv ***
/*
  Shared constants, types and helper functions of the resource map decoder:
  register indices and byte addresses, field positions, reset values,
  window sizes of the on-chip resources and the operating mode encoding.
  Assumes a 16-bit CPU address space and an AXI4-Lite register port with
  8-bit byte addresses.
*/
package rmd_pkg;

  localparam int ADDR_W = 16;
  localparam int AXI_AW = 8;

  // register indices; byte address is four times the index
  localparam logic [7:0] RAM_POS_IDX = 8'h10;
  localparam logic [7:0] EE_POS_IDX = 8'h12;
  localparam logic [7:0] MAP_CTRL_IDX = 8'h13;
  localparam logic [7:0] STATUS_IDX = 8'h14;
  localparam logic [7:0] RAM_POS_ADDR = {RAM_POS_IDX[5:0], 2'b00};
  localparam logic [7:0] EE_POS_ADDR = {EE_POS_IDX[5:0], 2'b00};
  localparam logic [7:0] MAP_CTRL_ADDR = {MAP_CTRL_IDX[5:0], 2'b00};
  localparam logic [7:0] STATUS_ADDR = {STATUS_IDX[5:0], 2'b00};

  // reset values
  localparam logic [7:0] RAM_POS_RST = 8'h00;
  localparam logic [7:0] EE_POS_RST = 8'h01;
  localparam logic [7:0] MAP_CTRL_RST_EXP = 8'h0C;
  localparam logic [7:0] MAP_CTRL_RST_SC = 8'h0F;

  // field positions
  localparam int RAM_BASE_LSB = 3;
  localparam int EE_BASE_LSB = 4;
  localparam int EE_ON_BIT = 0;
  localparam int SWAP_BIT = 7;
  localparam int NARROW_BIT = 6;
  localparam int FSTR_LSB = 4;
  localparam int XSTR_LSB = 2;
  localparam int LOW_EN_BIT = 1;
  localparam int HIGH_EN_BIT = 0;
  localparam int REFUSED_BIT = 6;

  // address windows
  localparam logic [15:0] REG_BLOCK_SIZE = 16'h0200;
  localparam logic [15:0] FOLLOW_OFFSET = 16'h0200;
  localparam logic [15:0] FOLLOW_SIZE = 16'h0200;
  localparam logic [15:0] RAM_SIZE = 16'h0800;
  localparam logic [15:0] EE_OFFSET = 16'h0C00;
  localparam logic [15:0] EE_SIZE = 16'h0400;
  localparam logic [15:0] A28_BASE = 16'h1000;
  localparam logic [15:0] A28_SWAP_BASE = 16'h9000;
  localparam logic [15:0] A28_SIZE = 16'h7000;
  localparam logic [15:0] A32_BASE = 16'h8000;
  localparam logic [15:0] A32_SWAP_BASE = 16'h0000;
  localparam logic [15:0] A32_SIZE = 16'h8000;

  // one-hot resource select positions
  localparam int SEL_REG = 0;
  localparam int SEL_RAM = 1;
  localparam int SEL_EE = 2;
  localparam int SEL_A28 = 3;
  localparam int SEL_A32 = 4;
  localparam int SEL_EXT = 5;
  localparam int SEL_NONE = 6;
  localparam int SEL_W = 7;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // {special_n, mode_b, mode_a}
  typedef enum logic [2:0] {
    MODE_SPEC_SC = 3'b000,
    MODE_SPEC_NAR = 3'b001,
    MODE_PERIPH = 3'b010,
    MODE_SPEC_WIDE = 3'b011,
    MODE_NORM_SC = 3'b100,
    MODE_NORM_NAR = 3'b101,
    MODE_RESERVED = 3'b110,
    MODE_NORM_WIDE = 3'b111
  } rmd_mode_e;

  function automatic logic in_block(input logic [15:0] a, input logic [15:0] base,
                                    input logic [15:0] size);
    logic [15:0] d;
    d = a - base;
    return d < size;
  endfunction : in_block

  function automatic logic is_expanded(input rmd_mode_e m);
    return m == MODE_SPEC_NAR || m == MODE_SPEC_WIDE || m == MODE_NORM_NAR
        || m == MODE_NORM_WIDE;
  endfunction : is_expanded

  function automatic logic is_single_chip(input rmd_mode_e m);
    return m == MODE_SPEC_SC || m == MODE_NORM_SC || m == MODE_RESERVED;
  endfunction : is_single_chip

  function automatic logic is_narrow(input rmd_mode_e m);
    return m == MODE_SPEC_NAR || m == MODE_NORM_NAR;
  endfunction : is_narrow

endpackage : rmd_pkg

// *** rtl/rmd_map_if.sv ***
/*
  Carrier between the register side and the address decoder: current map
  settings and address in, one-hot resource select out.
  Assumes both ends run on the same clock; the decode is combinational.
*/
`timescale 1ns/1ps
interface rmd_map_if;
  import rmd_pkg::*;
  logic [4:0] reg_base;
  logic [4:0] ram_base;
  logic [3:0] ee_base;
  logic ee_on;
  logic swap;
  logic low_en;
  logic high_en;
  rmd_mode_e mode;
  logic [15:0] addr;
  logic [SEL_W-1:0] sel;
  logic follow;

  modport cfg_src (output reg_base, ram_base, ee_base, ee_on, swap, low_en, high_en,
                   mode, addr, input sel, follow);
  modport decoder (input reg_base, ram_base, ee_base, ee_on, swap, low_en, high_en,
                   mode, addr, output sel, follow);
endinterface : rmd_map_if

// *** rtl/rmd_addr_decode.sv ***
/*
  Combinational address decoder: picks exactly one resource for an address
  by fixed precedence, and flags the register-following window.
  Assumes settings arrive stable from the register side.
*/
`timescale 1ns/1ps
module rmd_addr_decode
  import rmd_pkg::*;
(
  rmd_map_if.decoder m
);

  logic [15:0] reg_base_a;
  logic [15:0] ram_base_a;
  logic [15:0] ee_base_a;
  logic hit_reg;
  logic hit_ram;
  logic hit_ee;
  logic hit_a28;
  logic hit_a32;

  always_comb begin
    reg_base_a = {m.reg_base, 11'h000};
    ram_base_a = {m.ram_base, 11'h000};
    ee_base_a = {m.ee_base, 12'h000} + EE_OFFSET;
    hit_reg = in_block(m.addr, reg_base_a, REG_BLOCK_SIZE);
    hit_ram = in_block(m.addr, ram_base_a, RAM_SIZE);
    hit_ee = m.ee_on && in_block(m.addr, ee_base_a, EE_SIZE);
    hit_a28 = m.low_en && in_block(m.addr, m.swap ? A28_SWAP_BASE : A28_BASE,
                                   A28_SIZE);
    hit_a32 = m.high_en && in_block(m.addr, m.swap ? A32_SWAP_BASE : A32_BASE,
                                    A32_SIZE);
    m.follow = in_block(m.addr, reg_base_a + FOLLOW_OFFSET, FOLLOW_SIZE);
    m.sel = '0;
    if (hit_reg) begin
      m.sel[SEL_REG] = 1'b1;
    end else if (hit_ram) begin
      m.sel[SEL_RAM] = 1'b1;
    end else if (hit_ee) begin
      m.sel[SEL_EE] = 1'b1;
    end else if (hit_a28) begin
      m.sel[SEL_A28] = 1'b1;
    end else if (hit_a32) begin
      m.sel[SEL_A32] = 1'b1;
    end else if (is_expanded(m.mode)) begin
      m.sel[SEL_EXT] = 1'b1;
    end else begin
      m.sel[SEL_NONE] = 1'b1;
    end
  end

endmodule : rmd_addr_decode

// *** rtl/rmd_resource_map.sv ***
/*
  Resource map decoder top: mapping registers behind an AXI4-Lite slave,
  operating mode capture, and a registered per-access decode giving the
  resource select, bus width, stretch and byte-lane information.
  Assumes mode straps are stable while aresetn is low, the register block
  position comes from outside, and the CPU address inputs are synchronous.
*/
// What this block does
// - RAM sits at zero after reset, movable to any 2K boundary.
// - RAM position bits 7..3 give base bits 15..11; low three read zero.
// - register block hides overlapped RAM; after reset the first 512 bytes.
// - position and mapping fields: write once normal, anytime special, read always.
// - EEPROM at 0C00 after reset; bits 7..4 give base bits 15..12.
// - EEPROM enable bit removes or places EEPROM; resets to one.
// - EEPROM enable held at one in single-chip modes.
// - swap bit exchanges positions of the 28K and 32K arrays.
// - array enables add or remove arrays; reset zero expanded, one single-chip.
// - narrow-follow bit makes following space use an 8-bit bus.
// - narrow-follow ignored in narrow, single-chip and peripheral modes.
// - following space sits right after register block and moves with it.
// - following-space stretch adds 0 to 3 E clocks there.
// - external stretch adds 0 to 3 E clocks; resets to three.
// - no stretch in single-chip or peripheral modes.
// - external resources reachable only in expanded modes.
// - RAM does misaligned word access; only it shows strobe and A0 high.
// - misaligned RAM word: addressed byte low half, next byte high half.
// - precedence: registers, RAM, EEPROM, arrays, external.
// - unclaimed addresses go external in expanded modes.
`timescale 1ns/1ps
module rmd_resource_map
  import rmd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic mode_special_n,
  input wire logic mode_b,
  input wire logic mode_a,
  input wire logic [4:0] reg_block_position,
  input wire logic cpu_valid,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_wide,
  input wire logic cpu_write,
  output logic cycle_valid,
  output logic cycle_write,
  output logic [SEL_W-1:0] resource_sel,
  output logic follow_space,
  output logic narrow_bus,
  output logic [1:0] stretch_cycles,
  output logic low_byte_strobe_n,
  output logic addr_bit0,
  output logic byte_swap
);

  rmd_mode_e mode_reg;
  logic [7:0] ram_position_reg;
  logic [7:0] eeprom_position_reg;
  logic [7:0] mapping_control_reg;
  logic ram_done_reg;
  logic ee_done_reg;
  logic map_done_reg;
  logic refused_reg;

  logic aw_held_reg;
  logic [AXI_AW-1:0] awaddr_reg;
  logic w_held_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  logic special;
  logic single_chip;
  logic do_write;
  logic lane0;
  logic wr_ram;
  logic wr_ee;
  logic wr_map;
  logic wr_status;
  logic wr_mapped;
  logic refuse_now;
  logic [7:0] status_view;
  logic [31:0] rd_next;
  logic [1:0] rresp_next;
  logic ext_access;

  rmd_mode_e pin_mode;
  rmd_map_if map_bus ();

  assign pin_mode = rmd_mode_e'({mode_special_n, mode_b, mode_a});
  assign special = ~mode_reg[2];
  assign single_chip = is_single_chip(mode_reg);

  // operating mode is caught from the straps while reset is held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= pin_mode;
    end
  end

  // AXI4-Lite write channel
  assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
  assign s_axi_wready = ~w_held_reg & ~bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign lane0 = wstrb_reg[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  always_comb begin
    wr_ram = do_write && lane0 && awaddr_reg == RAM_POS_ADDR;
    wr_ee = do_write && lane0 && awaddr_reg == EE_POS_ADDR;
    wr_map = do_write && lane0 && awaddr_reg == MAP_CTRL_ADDR;
    wr_status = do_write && lane0 && awaddr_reg == STATUS_ADDR;
    wr_mapped = awaddr_reg == RAM_POS_ADDR || awaddr_reg == EE_POS_ADDR
             || awaddr_reg == MAP_CTRL_ADDR || awaddr_reg == STATUS_ADDR;
    refuse_now = !special && ((wr_ram && ram_done_reg) || (wr_map && map_done_reg)
             || (wr_ee && ee_done_reg));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_mapped ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // mapping registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ram_position_reg <= RAM_POS_RST;
      ram_done_reg <= 1'b0;
    end else if (wr_ram && (special || !ram_done_reg)) begin
      ram_position_reg <= {wdata_reg[7:RAM_BASE_LSB], 3'h0};
      ram_done_reg <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eeprom_position_reg <= EE_POS_RST;
      ee_done_reg <= 1'b0;
    end else if (wr_ee) begin
      if (special || !ee_done_reg) begin
        eeprom_position_reg[7:EE_BASE_LSB] <= wdata_reg[7:EE_BASE_LSB];
        ee_done_reg <= 1'b1;
      end
      eeprom_position_reg[EE_ON_BIT] <= wdata_reg[EE_ON_BIT] | single_chip;
    end else if (single_chip) begin
      eeprom_position_reg[EE_ON_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mapping_control_reg <= is_single_chip(pin_mode) ? MAP_CTRL_RST_SC
                                                      : MAP_CTRL_RST_EXP;
      map_done_reg <= 1'b0;
    end else if (wr_map && (special || !map_done_reg)) begin
      mapping_control_reg <= wdata_reg[7:0];
      map_done_reg <= 1'b1;
    end
  end

  // refused write-once attempts; a new refusal wins over a clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      refused_reg <= 1'b0;
    end else if (refuse_now) begin
      refused_reg <= 1'b1;
    end else if (wr_status && wdata_reg[REFUSED_BIT]) begin
      refused_reg <= 1'b0;
    end
  end

  // AXI4-Lite read channel
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign status_view = {1'b0, refused_reg, map_done_reg, ee_done_reg, ram_done_reg,
                        mode_reg};

  always_comb begin
    rd_next = '0;
    rresp_next = RESP_OKAY;
    case (s_axi_araddr)
      RAM_POS_ADDR: begin
        rd_next[7:0] = ram_position_reg;
      end
      EE_POS_ADDR: begin
        rd_next[7:0] = eeprom_position_reg;
      end
      MAP_CTRL_ADDR: begin
        rd_next[7:0] = mapping_control_reg;
      end
      STATUS_ADDR: begin
        rd_next[7:0] = status_view;
      end
      default: begin
        rresp_next = RESP_DECERR;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_next;
      rresp_reg <= rresp_next;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // address decode
  assign map_bus.reg_base = reg_block_position;
  assign map_bus.ram_base = ram_position_reg[7:RAM_BASE_LSB];
  assign map_bus.ee_base = eeprom_position_reg[7:EE_BASE_LSB];
  assign map_bus.ee_on = eeprom_position_reg[EE_ON_BIT];
  assign map_bus.swap = mapping_control_reg[SWAP_BIT];
  assign map_bus.low_en = mapping_control_reg[LOW_EN_BIT];
  assign map_bus.high_en = mapping_control_reg[HIGH_EN_BIT];
  assign map_bus.mode = mode_reg;
  assign map_bus.addr = cpu_addr;

  rmd_addr_decode u_decode (
    .m(map_bus.decoder)
  );

  assign ext_access = map_bus.sel[SEL_EXT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cycle_valid <= 1'b0;
      cycle_write <= 1'b0;
      resource_sel <= '0;
      follow_space <= 1'b0;
    end else begin
      cycle_valid <= cpu_valid;
      cycle_write <= cpu_write;
      resource_sel <= map_bus.sel;
      follow_space <= ext_access && map_bus.follow;
    end
  end

  // external bus width
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      narrow_bus <= 1'b0;
    end else if (ext_access && is_narrow(mode_reg)) begin
      narrow_bus <= 1'b1;
    end else if (ext_access && map_bus.follow) begin
      narrow_bus <= mapping_control_reg[NARROW_BIT];
    end else begin
      narrow_bus <= 1'b0;
    end
  end

  // E clock stretch only on external cycles of expanded modes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stretch_cycles <= 2'h0;
    end else if (!ext_access) begin
      stretch_cycles <= 2'h0;
    end else if (map_bus.follow) begin
      stretch_cycles <= mapping_control_reg[FSTR_LSB+:2];
    end else begin
      stretch_cycles <= mapping_control_reg[XSTR_LSB+:2];
    end
  end

  // size strobe and byte lanes; only RAM keeps a misaligned word whole
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_byte_strobe_n <= 1'b1;
      addr_bit0 <= 1'b0;
      byte_swap <= 1'b0;
    end else if (cpu_wide && cpu_addr[0] && !map_bus.sel[SEL_RAM]) begin
      low_byte_strobe_n <= 1'b0;
      addr_bit0 <= 1'b1;
      byte_swap <= 1'b0;
    end else begin
      low_byte_strobe_n <= ~(cpu_wide ^ cpu_addr[0]);
      addr_bit0 <= cpu_addr[0];
      byte_swap <= cpu_wide && cpu_addr[0];
    end
  end

endmodule : rmd_resource_map

// *** tb/rmd_resource_map_asserts.sv ***
/*
  Concurrent checks on the resource map decoder top ports: one-hot select,
  register block and following window, mode limits, byte lane rules.
  Assumes mode straps are stable while aresetn is low.
*/
`timescale 1ns/1ps
module rmd_resource_map_asserts
  import rmd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic mode_b,
  input wire logic mode_a,
  input wire logic [4:0] reg_block_position,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_wide,
  input wire logic [SEL_W-1:0] resource_sel,
  input wire logic follow_space,
  input wire logic narrow_bus,
  input wire logic [1:0] stretch_cycles,
  input wire logic low_byte_strobe_n,
  input wire logic addr_bit0,
  input wire logic byte_swap
);
  logic [1:0] mode_q;
  logic live_q;
  logic wide_q;
  logic [15:0] addr_q;
  logic [4:0] rbp_q;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // straps as captured by the design during reset
  always_ff @(posedge aclk) begin
    if (!aresetn) mode_q <= {mode_b, mode_a};
  end
  always_ff @(posedge aclk) begin
    live_q <= aresetn;
    wide_q <= cpu_wide;
    addr_q <= cpu_addr;
    rbp_q <= reg_block_position;
  end
  sel_onehot_a: assert property (live_q |-> $onehot(resource_sel))
    else $error("resource select is not one-hot");
  reg_win_a: assert property (
    cpu_addr[15:9] == {reg_block_position, 2'b00} |=> resource_sel[SEL_REG])
    else $error("register block did not win its window");
  follow_win_a: assert property (
    follow_space |-> resource_sel[SEL_EXT] && addr_q[15:9] == {rbp_q, 2'b01})
    else $error("following window flagged off its place");
  ext_mode_a: assert property (resource_sel[SEL_EXT] |-> mode_q[0])
    else $error("external select outside expanded modes");
  stretch_mode_a: assert property (!mode_q[0] |-> stretch_cycles == 2'h0)
    else $error("stretch outside expanded modes");
  stretch_ext_a: assert property (stretch_cycles != 2'h0 |-> resource_sel[SEL_EXT])
    else $error("stretch on an internal access");
  narrow_only_a: assert property (
    narrow_bus |-> resource_sel[SEL_EXT] && (mode_q == 2'b01 || follow_space))
    else $error("narrow bus where it does not belong");
  narrow_mode_a: assert property (
    live_q && mode_q == 2'b01 && resource_sel[SEL_EXT] |-> narrow_bus)
    else $error("narrow mode access not narrow");
  strobe_ram_a: assert property (low_byte_strobe_n && addr_bit0 |-> resource_sel[SEL_RAM])
    else $error("strobe and bit 0 both high off the RAM");
  ram_swap_a: assert property (
    live_q && wide_q && addr_q[0] && resource_sel[SEL_RAM]
      |-> byte_swap && low_byte_strobe_n && addr_bit0)
    else $error("misaligned RAM word not swapped");
endmodule : rmd_resource_map_asserts

bind rmd_resource_map rmd_resource_map_asserts chk_i (
  .aclk(aclk), .aresetn(aresetn), .mode_b(mode_b), .mode_a(mode_a),
  .reg_block_position(reg_block_position), .cpu_addr(cpu_addr), .cpu_wide(cpu_wide),
  .resource_sel(resource_sel), .follow_space(follow_space), .narrow_bus(narrow_bus),
  .stretch_cycles(stretch_cycles), .low_byte_strobe_n(low_byte_strobe_n),
  .addr_bit0(addr_bit0), .byte_swap(byte_swap)
);

// *** tb/rmd_ext_bus_model.sv ***
/*
  External bus partner: counts the valid cycles routed off chip to the external bus.
  Assumes registered decode outputs on the same clock.
*/
`timescale 1ns/1ps
module rmd_ext_bus_model
  import rmd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cycle_valid,
  input wire logic [SEL_W-1:0] resource_sel,
  output int ext_count
);
  // only cycles routed to the bus reach the external devices
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_count <= 0;
    end else if (cycle_valid && resource_sel[SEL_EXT]) begin
      ext_count <= ext_count + 1;
    end
  end
endmodule : rmd_ext_bus_model

// *** tb/resource_map_decoder_bench.sv ***
/*
  Self-checking bench: register traffic over AXI4-Lite, decode traffic, partner.
  Assumes rmd_pkg, the checker and the partner model are compiled first.
*/
`timescale 1ns/1ps
module resource_map_decoder_bench;
  import rmd_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic mode_special_n = 1, mode_b = 1, mode_a = 1;
  logic [4:0] rbp = 0;
  logic cpu_valid = 0, cpu_wide = 0, cpu_write = 0;
  logic [15:0] cpu_addr = 0;
  logic awready, wready, bvalid, arready, rvalid, cycle_valid, narrow_bus, sn, a0, bs, cw, fs;
  logic [1:0] bresp, rresp, stretch_cycles;
  logic [31:0] rdata;
  logic [SEL_W-1:0] resource_sel;
  logic [33:0] b_q[$], r_q[$], d_q[$];
  logic [7:0] sh [3];
  logic [7:0] radr [3] = '{RAM_POS_ADDR, EE_POS_ADDR, MAP_CTRL_ADDR};
  bit once [3];
  logic [2:0] md;
  int n_errors = 0, check_count = 0, exp_ext = 0, ext_count;

  rmd_resource_map dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .mode_special_n(mode_special_n),
    .mode_b(mode_b), .mode_a(mode_a), .reg_block_position(rbp), .cpu_valid(cpu_valid),
    .cpu_addr(cpu_addr), .cpu_wide(cpu_wide), .cpu_write(cpu_write),
    .cycle_valid(cycle_valid), .cycle_write(cw), .resource_sel(resource_sel),
    .follow_space(fs), .narrow_bus(narrow_bus), .stretch_cycles(stretch_cycles),
    .low_byte_strobe_n(sn), .addr_bit0(a0), .byte_swap(bs));
  rmd_ext_bus_model ext_i (.aclk(aclk), .aresetn(aresetn), .cycle_valid(cycle_valid),
    .resource_sel(resource_sel), .ext_count(ext_count));

  always #4 aclk = ~aclk;

  task automatic chk(input string what, input logic [33:0] seen, input logic [33:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic summarize();
    n_errors += b_q.size() + r_q.size() + d_q.size();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  // expected {follow, stretch, narrow, strobe_n, a0, swap, select} from the shadow settings
  function automatic logic [13:0] ref_dec(input logic [15:0] a, input logic w);
    logic [6:0] s;
    logic fol;
    fol = a[15:9] == {rbp, 2'b01};
    if (a[15:9] == {rbp, 2'b00}) s = 7'h01;
    else if (a[15:11] == sh[0][7:3]) s = 7'h02;
    else if (sh[1][0] && a[15:10] == {sh[1][7:4], 2'b11}) s = 7'h04;
    else if (sh[2][1] && a[15] == sh[2][7] && a[14:12] != 3'h0) s = 7'h08;
    else if (sh[2][0] && a[15] != sh[2][7]) s = 7'h10;
    else s = md[0] ? 7'h20 : 7'h40;
    return {s[5] && fol, s[5] ? (fol ? sh[2][5:4] : sh[2][3:2]) : 2'h0,
            s[5] && (md[1:0] == 2'b01 || fol && sh[2][6]),
            w ? {a[0] && s[1], a[0], a[0] && s[1]} : {!a[0], a[0], 1'b0}, s};
  endfunction : ref_dec

  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] rsp);
    @(posedge aclk);
    cpu_valid <= 1'b0;
    b_q.push_back(34'(rsp));
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] rsp);
    @(posedge aclk);
    cpu_valid <= 1'b0;
    r_q.push_back({rsp, 24'h0, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask : axi_rd

  task automatic reg_wr(input int k, input logic [7:0] d);
    axi_wr(radr[k], d, RESP_OKAY);
    if (!md[2] || !once[k]) sh[k] = d & (k == 0 ? 8'hF8 : k == 1 ? 8'hF1 : 8'hFF);
    else if (k == 1) sh[1][0] = d[0];
    once[k] = 1'b1;
    if (!md[0] && md[2:1] != 2'b01) sh[1][0] = 1'b1;
  endtask : reg_wr

  task automatic rd_all();
    for (int k = 0; k < 3; k++) axi_rd(radr[k], sh[k], RESP_OKAY);
  endtask : rd_all

  task automatic dec(input logic [15:0] a, input logic w);
    logic wr;
    wr = 1'($urandom);
    @(posedge aclk);
    cpu_valid <= 1'b1;
    cpu_addr <= a;
    cpu_wide <= w;
    cpu_write <= wr;
    d_q.push_back(34'({wr, ref_dec(a, w)}));
    if (ref_dec(a, w) & 14'h20) exp_ext++;
  endtask : dec

  task automatic rst(input logic [2:0] m);
    @(posedge aclk);
    cpu_valid <= 1'b0;
    aresetn <= 1'b0;
    rbp <= 5'h00;
    {mode_special_n, mode_b, mode_a} <= m;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    md = m;
    exp_ext = 0;
    once = '{0, 0, 0};
    sh = '{RAM_POS_RST, EE_POS_RST,
      (m[0] || m[2:1] == 2'b01) ? MAP_CTRL_RST_EXP : MAP_CTRL_RST_SC};
  endtask : rst

  always @(posedge aclk) begin
    if (bvalid && bready) chk("write response", 34'(bresp), b_q.pop_front());
    if (rvalid && rready) chk("read data", {rresp, rdata}, r_q.pop_front());
    if (cycle_valid) chk("decode", 34'({cw, fs, stretch_cycles, narrow_bus, sn, a0, bs,
      resource_sel}), d_q.pop_front());
  end

  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    summarize();
  end

  initial begin
    void'($urandom(89));
    rst(3'b111);
    rd_all();
    axi_rd(8'h04, 8'h00, RESP_DECERR);
    axi_wr(8'hFC, 8'h55, RESP_DECERR);
    dec(16'h0000, 0);
    dec(16'h01FF, 1);
    dec(16'h0200, 0);
    dec(16'h0201, 1);
    dec(16'h0C00, 0);
    dec(16'h1000, 1);
    dec(16'hFFFF, 0);
    reg_wr(0, 8'h4F);
    reg_wr(1, 8'h2F);
    reg_wr(2, 8'hE6);
    rbp <= 5'h01;
    rd_all();
    dec(16'h0A00, 1);
    dec(16'h0800, 0);
    dec(16'h4801, 1);
    dec(16'h2C00, 0);
    dec(16'h9000, 0);
    dec(16'h0400, 0);
    repeat (40) dec(16'($urandom), 1'($urandom));
    reg_wr(0, 8'hF8);
    reg_wr(1, 8'h30);
    reg_wr(2, 8'h01);
    dec(16'h2C00, 0);
    rd_all();
    axi_rd(STATUS_ADDR, 8'h7F, RESP_OKAY);
    axi_wr(STATUS_ADDR, 8'h40, RESP_OKAY);
    axi_rd(STATUS_ADDR, 8'h3F, RESP_OKAY);
    chk("external cycles", 34'(ext_count), 34'(exp_ext));
    rst(3'b011);
    reg_wr(0, 8'h80);
    for (int i = 0; i < 4; i++) begin
      reg_wr(2, {1'b0, i[0], i[1:0], ~i[1:0], 2'b00});
      dec(16'h0200, 1);
      dec(16'h4000, 0);
    end
    rst(3'b001);
    reg_wr(2, 8'h40);
    dec(16'h4000, 1);
    dec(16'h4001, 1);
    rst(3'b100);
    rd_all();
    reg_wr(1, 8'h00);
    dec(16'h1000, 0);
    dec(16'h8000, 1);
    dec(16'h0C00, 0);
    reg_wr(2, 8'h3C);
    dec(16'h4000, 0);
    repeat (10) dec(16'($urandom), 1'($urandom));
    rd_all();
    rst(3'b000);
    reg_wr(0, 8'h0F);
    reg_wr(0, 8'h10);
    reg_wr(1, 8'h00);
    dec(16'h1000, 1);
    rd_all();
    rst(3'b110);
    axi_rd(MAP_CTRL_ADDR, MAP_CTRL_RST_SC, RESP_OKAY);
    rst(3'b010);
    reg_wr(2, 8'h7C);
    dec(16'h4000, 0);
    repeat (3) @(posedge aclk);
    summarize();
  end
endmodule : resource_map_decoder_bench
